// >>> include/lcs_pkg.sv
package lcs_pkg;
	// word indices; byte address is four times the index
	localparam logic [5:0] IDX_SETTLE_CH2 = 6'h12;
	localparam logic [5:0] IDX_SETTLE_CH3 = 6'h13;
	localparam logic [5:0] IDX_CLKDIV_CH0 = 6'h14;
	localparam logic [5:0] IDX_CONTROL = 6'h18;
	localparam logic [5:0] IDX_STATUS = 6'h19;
	localparam logic [5:0] IDX_IRQ_CLEAR = 6'h1a;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h1b;
	localparam int ADDR_W = 8;
	// reset values
	localparam logic [15:0] SETTLE_RESET = 16'h0000;
	localparam logic [15:0] CLKDIV_RESET = 16'h0000;
	// clock divider fields
	localparam int REF_DIV_LSB = 0;
	localparam int REF_DIV_MSB = 9;
	localparam int FIN_SEL_LSB = 12;
	localparam int FIN_SEL_MSB = 13;
	localparam logic [1:0] FIN_DIV1 = 2'h1;
	localparam logic [1:0] FIN_DIV2 = 2'h2;
	// control fields
	localparam int CTL_START_CH2 = 0;
	localparam int CTL_START_CH3 = 1;
	localparam int CTL_WARN_EN = 2;
	// status / interrupt fields
	localparam int EVT_W = 3;
	localparam int EVT_CONV_CH2 = 0;
	localparam int EVT_CONV_CH3 = 1;
	localparam int EVT_AMP_WARN = 2;
	localparam int STS_BUSY = 8;
	localparam int STS_CHANNEL = 9;
	localparam int STS_PEND_CH2 = 10;
	localparam int STS_PEND_CH3 = 11;
	// settle timing in reference clock periods
	localparam logic [19:0] SETTLE_MIN_PERIODS = 20'h00020;
	localparam int SETTLE_MULT_SHIFT = 4;
	localparam logic [15:0] SETTLE_SHORT_MAX = 16'h0001;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETTLE = 2'b01,
		ST_START = 2'b11
	} lcs_state_type;
endpackage

// >>> logic/lcs_settle_refdiv.sv
`timescale 1ns/1ns
// Behaviour
// R1 - a conversion on a channel starts only after that channel's settle interval has elapsed.
// R2 - at conversion start an unsettled amplitude raises a warning only when warning reporting is enabled.
// R3 - a settle count of zero or one gives 32 reference clock periods.
// R4 - a settle count of two or more gives the count times 16 reference clock periods.
// R5 - the reference clock is the master clock divided by the 10-bit divider field in bits 9:0.
// R6 - the host never writes a divider of zero, which is reserved.
// R7 - sensor select code 01 passes the differential sensor frequency undivided.
// R8 - sensor select code 10 halves the sensor frequency.
// R9 - a single-ended sensor is always run with select code 10.
// R10 - the host writes zeros to the reserved fields at bits 15:14 and 11:10.
module lcs_settle_refdiv
#(
	parameter int REF_DIV_W = 10,
	parameter int SETTLE_W = 16
)
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [lcs_pkg::ADDR_W-1:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	input wire logic [3:0] byteenable_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	input wire logic amp_settled_in,
	input wire logic sensor_clk_in,
	output logic ref_tick_out,
	output logic sensor_tick_out,
	output logic conv_start_out,
	output logic conv_channel_out,
	output logic amp_warning_out,
	output logic irq_out
);
	import lcs_pkg::*;

	generate
		if (REF_DIV_W != 10 || SETTLE_W != 16)
		begin : g_check
			$error("lcs_settle_refdiv: field widths are fixed");
		end
	endgenerate

	logic [1:0] rst_sync_r;
	logic rst_n;
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// pin inputs: three stages, a change counts once stages 2 and 3 agree
	logic [1:0] pin_raw;
	logic [1:0] pin_flt;
	assign pin_raw = {sensor_clk_in, amp_settled_in};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_sync
			logic [2:0] s_r;
			logic f_r;
			logic f_nxt;
			always_comb
			begin
				f_nxt = (s_r[1] == s_r[2]) ? s_r[2] : f_r;
			end
			always_ff @(posedge clock_in or negedge rst_n)
			begin
				if (!rst_n)
				begin
					s_r <= 3'h0;
					f_r <= 1'b0;
				end
				else
				begin
					s_r <= {s_r[1:0], pin_raw[gi]};
					f_r <= f_nxt;
				end
			end
			assign pin_flt[gi] = f_r;
		end
	endgenerate

	// registers and bus state
	logic [15:0] settle2_r, settle2_nxt, settle3_r, settle3_nxt;
	logic [15:0] clkdiv_r, clkdiv_nxt;
	logic warn_en_r, warn_en_nxt;
	logic [EVT_W-1:0] status_r, status_nxt, enable_r, enable_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic [1:0] pend_r, pend_nxt;
	logic [5:0] idx;
	logic aligned, wr_ok;
	logic [EVT_W-1:0] evt_set, evt_clr;
	logic [15:0] wmask;

	// engine state
	lcs_state_type state_r, state_nxt;
	logic [19:0] remain_r, remain_nxt;
	logic chan_r, chan_nxt;
	logic [REF_DIV_W-1:0] ref_cnt_r, ref_cnt_nxt;
	logic ref_tick_r, ref_tick_nxt;
	logic sens_prev_r, sens_prev_nxt, sens_half_r, sens_half_nxt;
	logic sens_tick_r, sens_tick_nxt;
	logic conv_r, conv_nxt, conv_ch_r, conv_ch_nxt, warn_r, warn_nxt;
	logic [REF_DIV_W-1:0] ref_div;
	logic [1:0] fin_sel;
	logic [15:0] sel_count;

	assign idx = address_in[7:2];
	assign aligned = (address_in[1:0] == 2'h0);
	assign wr_ok = write_in && !wait_r && aligned;
	assign wmask = {{8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
	assign ref_div = clkdiv_r[REF_DIV_MSB:REF_DIV_LSB];
	assign fin_sel = clkdiv_r[FIN_SEL_MSB:FIN_SEL_LSB];

	always_comb
	begin
		settle2_nxt = settle2_r;
		settle3_nxt = settle3_r;
		clkdiv_nxt = clkdiv_r;
		warn_en_nxt = warn_en_r;
		enable_nxt = enable_r;
		evt_clr = '0;
		pend_nxt = pend_r;
		// one wait cycle, then the answer stands for one cycle
		wait_nxt = !((read_in || write_in) && wait_r);
		rdata_nxt = 32'h0;
		if ((read_in || write_in) && wait_r && aligned)
		begin
			if (idx == IDX_SETTLE_CH2)
				rdata_nxt = {16'h0, settle2_r};
			else if (idx == IDX_SETTLE_CH3)
				rdata_nxt = {16'h0, settle3_r};
			else if (idx == IDX_CLKDIV_CH0)
				rdata_nxt = {16'h0, clkdiv_r};
			else if (idx == IDX_CONTROL)
				rdata_nxt = {29'h0, warn_en_r, 2'h0};
			else if (idx == IDX_STATUS)
				rdata_nxt = {20'h0, pend_r, chan_r,
					state_r != ST_IDLE, 5'h0, status_r};
			else if (idx == IDX_IRQ_ENABLE)
				rdata_nxt = {29'h0, enable_r};
			else
				rdata_nxt = 32'h0;
		end
		if (wr_ok)
		begin
			if (idx == IDX_SETTLE_CH2)
				settle2_nxt = (settle2_r & ~wmask) |
					(writedata_in[15:0] & wmask);
			else if (idx == IDX_SETTLE_CH3)
				settle3_nxt = (settle3_r & ~wmask) |
					(writedata_in[15:0] & wmask);
			// reserved bits stored as written; host keeps them zero
			else if (idx == IDX_CLKDIV_CH0)
				clkdiv_nxt = (clkdiv_r & ~wmask) |
					(writedata_in[15:0] & wmask); // R10
			else if (idx == IDX_CONTROL && byteenable_in[0])
			begin
				warn_en_nxt = writedata_in[CTL_WARN_EN];
				pend_nxt = pend_r | {writedata_in[CTL_START_CH3],
					writedata_in[CTL_START_CH2]};
			end
			else if (idx == IDX_IRQ_CLEAR && byteenable_in[0])
				evt_clr = writedata_in[EVT_W-1:0];
			else if (idx == IDX_IRQ_ENABLE && byteenable_in[0])
				enable_nxt = writedata_in[EVT_W-1:0];
		end
		if (state_r == ST_IDLE)
		begin
			if (pend_r[0])
				pend_nxt[0] = 1'b0;
			else if (pend_r[1])
				pend_nxt[1] = 1'b0;
		end
		// set wins over a clear in the same cycle
		status_nxt = (status_r & ~evt_clr) | evt_set;
		irq_nxt = |(status_nxt & enable_nxt);
	end

	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			settle2_r <= SETTLE_RESET;
			settle3_r <= SETTLE_RESET;
			clkdiv_r <= CLKDIV_RESET;
			warn_en_r <= 1'b0;
			status_r <= '0;
			enable_r <= '0;
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
			irq_r <= 1'b0;
			pend_r <= 2'h0;
		end
		else
		begin
			settle2_r <= settle2_nxt;
			settle3_r <= settle3_nxt;
			clkdiv_r <= clkdiv_nxt;
			warn_en_r <= warn_en_nxt;
			status_r <= status_nxt;
			enable_r <= enable_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			pend_r <= pend_nxt;
		end
	end

	always_comb
	begin
		// reserved zero divider gives no reference ticks at all
		ref_cnt_nxt = '0;
		ref_tick_nxt = 1'b0;
		if (ref_div != '0) // R6
		begin
			if (ref_cnt_r >= ref_div - 10'h001) // R5
				ref_tick_nxt = 1'b1;
			else
				ref_cnt_nxt = ref_cnt_r + 10'h001;
		end
		// sensor edge counting; other select codes pass no ticks
		sens_prev_nxt = pin_flt[1];
		sens_half_nxt = sens_half_r;
		sens_tick_nxt = 1'b0;
		if (pin_flt[1] && !sens_prev_r)
		begin
			if (fin_sel == FIN_DIV1)
				sens_tick_nxt = 1'b1; // R7
			else if (fin_sel == FIN_DIV2)
			begin
				sens_half_nxt = !sens_half_r;
				sens_tick_nxt = sens_half_r; // R8 R9
			end
		end
		state_nxt = state_r;
		remain_nxt = remain_r;
		chan_nxt = chan_r;
		conv_nxt = 1'b0;
		conv_ch_nxt = conv_ch_r;
		warn_nxt = 1'b0;
		evt_set = '0;
		sel_count = pend_r[0] ? settle2_r : settle3_r;
		case (state_r)
			ST_IDLE:
			begin
				if (pend_r != 2'h0)
				begin
					chan_nxt = !pend_r[0];
					state_nxt = ST_SETTLE;
					if (sel_count <= SETTLE_SHORT_MAX)
						remain_nxt = SETTLE_MIN_PERIODS; // R3
					else
						remain_nxt = 20'(sel_count) << SETTLE_MULT_SHIFT; // R4
				end
			end
			ST_SETTLE:
			begin
				if (ref_tick_r)
				begin
					remain_nxt = remain_r - 20'h00001;
					if (remain_r == 20'h00001)
						state_nxt = ST_START; // R1
				end
			end
			ST_START:
			begin
				conv_nxt = 1'b1;
				conv_ch_nxt = chan_r;
				evt_set[EVT_CONV_CH2] = !chan_r;
				evt_set[EVT_CONV_CH3] = chan_r;
				// amplitude sampled at the start moment only
				if (!pin_flt[0] && warn_en_r)
				begin
					warn_nxt = 1'b1; // R2
					evt_set[EVT_AMP_WARN] = 1'b1; // R2
				end
				state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			remain_r <= 20'h0;
			chan_r <= 1'b0;
			ref_cnt_r <= '0;
			ref_tick_r <= 1'b0;
			sens_prev_r <= 1'b0;
			sens_half_r <= 1'b0;
			sens_tick_r <= 1'b0;
			conv_r <= 1'b0;
			conv_ch_r <= 1'b0;
			warn_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			remain_r <= remain_nxt;
			chan_r <= chan_nxt;
			ref_cnt_r <= ref_cnt_nxt;
			ref_tick_r <= ref_tick_nxt;
			sens_prev_r <= sens_prev_nxt;
			sens_half_r <= sens_half_nxt;
			sens_tick_r <= sens_tick_nxt;
			conv_r <= conv_nxt;
			conv_ch_r <= conv_ch_nxt;
			warn_r <= warn_nxt;
		end
	end

	assign readdata_out = rdata_r;
	assign waitrequest_out = wait_r;
	assign ref_tick_out = ref_tick_r;
	assign sensor_tick_out = sens_tick_r;
	assign conv_start_out = conv_r;
	assign conv_channel_out = conv_ch_r;
	assign amp_warning_out = warn_r;
	assign irq_out = irq_r;
endmodule

// >>> sim/lcs_sensor_model.sv
`timescale 1ns/1ns
// free-running oscillation; 5 MHz sits in both select ranges
module lcs_sensor_model
(
	input wire logic amp_ok_in,
	output logic sensor_clk_out,
	output logic amp_settled_out
);
	initial sensor_clk_out = 1'b0;
	always #100 sensor_clk_out = ~sensor_clk_out;
	assign amp_settled_out = amp_ok_in;
endmodule

// >>> sim/lcs_settle_refdiv_asserts.sv
`timescale 1ns/1ns
module lcs_settle_refdiv_asserts
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic waitrequest_out,
	input wire logic ref_tick_out,
	input wire logic sensor_tick_out,
	input wire logic conv_start_out,
	input wire logic amp_warning_out,
	input wire logic irq_out
);
	// saturates; only the lower bound is judged
	logic [5:0] ticks_r;
	logic [5:0] ticks_nxt;
	// divider resets to the reserved zero: no tick before the first write
	logic wr_seen_r;
	logic wr_seen_nxt;
	always_comb
	begin
		wr_seen_nxt = wr_seen_r | (write_in && !waitrequest_out);
		ticks_nxt = ticks_r;
		if (conv_start_out)
			ticks_nxt = 6'h00;
		else if (ref_tick_out && ticks_r != 6'h3f)
			ticks_nxt = ticks_r + 6'h01;
	end
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ticks_r <= 6'h00;
			wr_seen_r <= 1'b0;
		end
		else
		begin
			ticks_r <= ticks_nxt;
			wr_seen_r <= wr_seen_nxt;
		end
	end
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_req;
		(read_in || write_in) && waitrequest_out;
	endsequence
	sequence s_ans;
		!waitrequest_out ##1 waitrequest_out;
	endsequence
	AST_BUS_ANSWER: assert property (s_req |=> s_ans)
		else $error("bus answer wrong");
	AST_BUS_QUIET: assert property
		(!read_in && !write_in && waitrequest_out |=> waitrequest_out)
		else $error("unasked answer");
	AST_SETTLE_MIN: assert property
		(conv_start_out |-> ticks_r >= 6'h20)
		else $error("settle too short");
	AST_START_ONE: assert property
		(conv_start_out |=> !conv_start_out)
		else $error("start too long");
	AST_WARN_AT_START: assert property
		(amp_warning_out |-> conv_start_out)
		else $error("warning off start");
	// a divider of one legally ticks every cycle, so no gap is judged
	AST_REF_QUIET: assert property
		(!wr_seen_r |-> !ref_tick_out)
		else $error("ref tick before divider set");
	AST_SENSOR_GAP: assert property
		(sensor_tick_out |=> (!sensor_tick_out) [*8])
		else $error("sensor tick gap");
	AST_IRQ_CAUSE: assert property ($rose(irq_out) |-> conv_start_out
		|| $past(conv_start_out) || $past(write_in && !waitrequest_out))
		else $error("irq without cause");
endmodule
bind lcs_settle_refdiv lcs_settle_refdiv_asserts lcs_settle_refdiv_asserts_i
	(.clock_in, .rst_n_in, .read_in, .write_in, .waitrequest_out,
	.ref_tick_out, .sensor_tick_out, .conv_start_out, .amp_warning_out,
	.irq_out);

// >>> sim/lcs_settle_refdiv_bench.sv
`timescale 1ns/1ns
module lcs_settle_refdiv_bench;
	import lcs_pkg::*;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] address_in = 8'h00;
	logic read_in = 1'b0;
	logic write_in = 1'b0;
	logic [31:0] writedata_in = 32'h0;
	logic amp_ok = 1'b1;
	logic [31:0] readdata_out, q;
	logic waitrequest_out, amp_settled_in, sensor_clk_in, ref_tick_out;
	logic sensor_tick_out, conv_start_out, conv_channel_out;
	logic amp_warning_out, irq_out;
	int miscompares = 0;
	int total_checks = 0;
	int n;
	always #5 clock_in = ~clock_in;
	lcs_sensor_model lcs_sensor_model_i(.amp_ok_in(amp_ok),
		.sensor_clk_out(sensor_clk_in), .amp_settled_out(amp_settled_in));
	lcs_settle_refdiv lcs_settle_refdiv_i(.clock_in, .rst_n_in,
		.address_in, .read_in, .write_in, .writedata_in,
		.byteenable_in(4'h3), .readdata_out, .waitrequest_out,
		.amp_settled_in, .sensor_clk_in, .ref_tick_out, .sensor_tick_out,
		.conv_start_out, .conv_channel_out, .amp_warning_out, .irq_out);
	task end_sim();
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task chk_rng(input string s, input int lo, input int hi, input int g);
		total_checks++;
		if (g < lo || g > hi)
		begin
			miscompares++;
			$display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, g);
		end
	endtask
	task bus(input logic w, input logic [5:0] i, input logic [15:0] d);
		@(posedge clock_in);
		address_in <= {i, 2'b00};
		read_in <= !w;
		write_in <= w;
		writedata_in <= {16'h0000, d};
		do
			@(posedge clock_in);
		while (waitrequest_out !== 1'b0);
		q = readdata_out;
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask
	task rd_chk(input string s, input logic [5:0] i, input logic [31:0] e);
		bus(1'b0, i, 16'h0000);
		chk(s, e, q);
	endtask
	// pulses seen over a fixed window
	task ticks(input logic s, input int cyc);
		n = 0;
		repeat (cyc)
		begin
			@(posedge clock_in);
			n += s ? sensor_tick_out : ref_tick_out;
		end
	endtask
	// divider is 2 here, so each settle period is two cycles
	task conv(input int i);
		logic [15:0] c;
		int nn;
		c = 16'(i * i);
		nn = (i * i < 2) ? 32 : i * i * 16;
		amp_ok <= (i == 0 || i == 3);
		bus(1'b1, {IDX_SETTLE_CH2[5:1], i[0]}, c);
		rd_chk("settle", {IDX_SETTLE_CH2[5:1], i[0]}, {16'h0, c});
		bus(1'b1, IDX_CONTROL, {13'h0, i == 0 || i == 2, i[0], !i[0]});
		n = 0;
		while (conv_start_out !== 1'b1 && n < 3000)
		begin
			@(posedge clock_in);
			n++;
		end
		chk_rng("settle time", 2 * nn, 2 * nn + 6, n);
		chk("warning", i == 2, amp_warning_out);
		@(posedge clock_in);
		chk("channel", i[0], conv_channel_out);
	endtask
	initial
	begin
		repeat (4) @(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		rd_chk("clkdiv", IDX_CLKDIV_CH0, 32'h0);
		rd_chk("settle", IDX_SETTLE_CH2, 32'h0);
		rd_chk("unmapped", 6'h3f, 32'h0);
		bus(1'b1, IDX_CLKDIV_CH0, 16'h1005);
		rd_chk("clkdiv", IDX_CLKDIV_CH0, 32'h1005);
		ticks(1'b0, 200);
		chk_rng("ref ticks", 39, 41, n);
		ticks(1'b1, 2000);
		chk_rng("sensor ticks", 99, 101, n);
		bus(1'b1, IDX_CLKDIV_CH0, 16'h2002);
		ticks(1'b1, 2000);
		chk_rng("sensor ticks", 49, 51, n);
		bus(1'b1, IDX_CLKDIV_CH0, 16'h0002);
		@(posedge clock_in);
		ticks(1'b1, 400);
		chk("sensor ticks off", 32'h0, n);
		bus(1'b1, IDX_CLKDIV_CH0, 16'h2002);
		bus(1'b1, IDX_IRQ_ENABLE, 16'h0007);
		for (int i = 0; i < 4; i++)
			conv(i);
		rd_chk("enable", IDX_IRQ_ENABLE, 32'h7);
		bus(1'b0, IDX_STATUS, 16'h0000);
		chk("status", 32'h7, q & 32'h7);
		chk("irq", 1'b1, irq_out);
		bus(1'b1, IDX_IRQ_ENABLE, 16'h0000);
		@(posedge clock_in);
		chk("irq masked", 1'b0, irq_out);
		bus(1'b1, IDX_IRQ_ENABLE, 16'h0007);
		bus(1'b1, IDX_IRQ_CLEAR, 16'h0007);
		rd_chk("clear", IDX_IRQ_CLEAR, 32'h0);
		chk("irq cleared", 1'b0, irq_out);
		bus(1'b0, IDX_STATUS, 16'h0000);
		chk("status", 32'h0, q & 32'h7);
		end_sim();
	end
	initial
	begin
		#200000;
		miscompares++;
		end_sim();
	end
endmodule
